// ==== bace_exec.sv ====
`timescale 1ns/1ps
`include "bace_consts.svh"
// Functional notes
// RQ1: bit AND into carry clears carry when source bit is zero.
// RQ2: inverted form uses complement of bit, stored bit untouched.
// RQ3: bit AND takes only direct bit source, changes only carry.
// RQ4: compare-branch jumps only when operands differ, operands kept.
// RQ5: branch target is pc plus three plus signed last byte.
// RQ6: compare-branch sets carry when destination below source unsigned.
// RQ7: compare-branch pairs: acc with direct/immediate, indirect/register with immediate.
// RQ8: clear accumulator zeroes it, updates negative and zero.
// RQ9: bit clear zeroes carry or direct bit; flags only for carry.
// RQ10: extended bit clear on port latch adds two states.
// RQ11: compare discards difference, destination keeps its value.
// RQ12: compare carry is borrow into top bit of top byte.
// RQ13: compare overflow on signed sign-mismatch result.
// RQ14: carry and overflow from the top byte of width used.
// RQ15: compare accepts all source modes, updates five flags.
// RQ16: complement accumulator inverts bits, updates negative and zero only.
// RQ17: compatibility map needs escape prefix for extended forms.
// RQ18: native map needs escape prefix for legacy indirect/bank forms.
// RQ19: dword compare zero- or one-extends sixteen-bit immediate.
// RQ20: negative copies result top bit, zero flags all-zero result.
module bace_exec (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             busy_o
);
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [31:0]          ctrl;
      logic [31:0]          opa;
      logic [31:0]          opb;
      logic [15:0]          pc;
      logic [7:0]           acc;
      bace_pkg::bace_flags_t flg;
      logic [7:0]           bits;
      logic [31:0]          res;
      logic                 taken;
      logic                 illegal;
      logic [1:0]           wait_cnt;
      bace_pkg::bace_state_t st;
      logic                 ack;
      logic [31:0]          rdat;
   } bace_state_s_t;

   bace_state_s_t s_q;
   bace_state_s_t s_d;
   bace_pkg::bace_cmp_t cmp_res;
   bace_pkg::bace_op_t  op;
   bace_pkg::bace_wid_t wid;
   logic [31:0] cmp_src;
   logic [31:0] cmp_dst;
   logic        srcbit;
   logic        legal;
   logic        hit_w;
   logic        go_ok;

   // byte-lane merge for register writes
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // negative and zero from an 8-bit result
   function automatic logic [1:0] nz8(input logic [7:0] v);
      return {v[7], v == 8'h00}; // RQ20
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      op  = bace_pkg::bace_op_t'(s_q.ctrl[`BACE_CTRL_OP_LO +: `BACE_CTRL_OP_W]);
      wid = bace_pkg::bace_wid_t'(s_q.ctrl[`BACE_CTRL_WID_LO +: 2]);
      // dword compare against a 16-bit immediate is extended first
      if (wid == bace_pkg::BACE_W32 && s_q.ctrl[`BACE_CTRL_SRCMODE +: 2] == 2'h2) begin
         cmp_src = {s_q.ctrl[`BACE_CTRL_ONEFILL] ? 16'hffff : 16'h0000,
                    s_q.opb[15:0]}; // RQ19
      end else begin
         cmp_src = s_q.opb;
      end
      cmp_dst = (op == bace_pkg::BACE_OP_COMPARE_BRANCH_NE_OP) ? {24'h000000, s_q.opa[7:0]} : s_q.opa;
      // operand bit, complemented view only; stored bit never written
      srcbit = s_q.bits[s_q.ctrl[`BACE_CTRL_BITSEL +: 3]] ^ s_q.ctrl[`BACE_CTRL_INVSRC]; // RQ2
      // escape prefix: compatibility map wants it on extended forms,
      // native map wants it on legacy indirect/bank forms
      if (s_q.ctrl[`BACE_CTRL_NATIVE]) begin
         legal = !s_q.ctrl[`BACE_CTRL_LEGACY] || s_q.ctrl[`BACE_CTRL_PREFIX]; // RQ18
      end else begin
         legal = s_q.ctrl[`BACE_CTRL_LEGACY] || s_q.ctrl[`BACE_CTRL_PREFIX]; // RQ17
      end
   end

   bace_compare u_cmp (
      .dst_i (cmp_dst),
      .src_i (cmp_src),
      .wid_i ((op == bace_pkg::BACE_OP_COMPARE_BRANCH_NE_OP) ? bace_pkg::BACE_W8 : wid),
      .res_o (cmp_res)
   );

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic hit;
      logic [1:0] nz;
      hit = wb_cyc_i && wb_stb_i && !s_q.ack;
      nz  = 2'b00;
      s_d = s_q;
      s_d.ack = hit;
      s_d.ctrl[`BACE_CTRL_GO] = 1'b0;
      // register writes
      if (hit && wb_we_i) begin
         case (wb_adr_i)
            `BACE_ADR_CTRL:  s_d.ctrl = lane_merge(s_q.ctrl, wb_dat_i, wb_sel_i);
            `BACE_ADR_OPA:   s_d.opa  = lane_merge(s_q.opa, wb_dat_i, wb_sel_i);
            `BACE_ADR_OPB:   s_d.opb  = lane_merge(s_q.opb, wb_dat_i, wb_sel_i);
            `BACE_ADR_PC: begin
               if (wb_sel_i[0]) s_d.pc[7:0] = wb_dat_i[7:0];
               if (wb_sel_i[1]) s_d.pc[15:8] = wb_dat_i[15:8];
            end
            `BACE_ADR_ACC: begin
               if (wb_sel_i[0]) s_d.acc = wb_dat_i[7:0];
               if (wb_sel_i[1]) s_d.bits = wb_dat_i[15:8];
            end
            `BACE_ADR_FLAGS: if (wb_sel_i[0]) s_d.flg = wb_dat_i[4:0];
            default: ;
         endcase
      end
      // reads
      case (wb_adr_i)
         `BACE_ADR_CTRL:  s_d.rdat = s_q.ctrl;
         `BACE_ADR_OPA:   s_d.rdat = s_q.opa;
         `BACE_ADR_OPB:   s_d.rdat = s_q.opb;
         `BACE_ADR_PC:    s_d.rdat = {16'h0000, s_q.pc};
         `BACE_ADR_ACC:   s_d.rdat = {16'h0000, s_q.bits, s_q.acc};
         `BACE_ADR_FLAGS: s_d.rdat = {27'h0000000, s_q.flg};
         `BACE_ADR_STAT:  s_d.rdat = {28'h0000000, s_q.illegal, s_q.taken,
                                      s_q.st != bace_pkg::BACE_ST_IDLE, 1'b0};
         `BACE_ADR_RES:   s_d.rdat = s_q.res;
         default:         s_d.rdat = 32'h0000_0000;
      endcase
      // execution
      case (s_q.st)
         bace_pkg::BACE_ST_IDLE: begin
            if (s_q.ctrl[`BACE_CTRL_GO]) begin
               s_d.illegal = !legal;
               s_d.taken   = 1'b0;
               s_d.st      = bace_pkg::BACE_ST_DONE;
               if (legal) begin
                  case (op)
                     bace_pkg::BACE_OP_ANLC: begin
                        // only direct bit source accepted; only carry changes
                        if (!s_q.ctrl[`BACE_CTRL_DIRBIT]) begin
                           s_d.illegal = 1'b1; // RQ3
                        end else if (!srcbit) begin
                           s_d.flg.cy = 1'b0; // RQ1
                        end
                     end
                     bace_pkg::BACE_OP_COMPARE_BRANCH_NE_OP: begin
                        // four pairings: acc/dir, acc/imm, ind/imm, reg/imm; opa not written
                        s_d.pc = s_q.pc + 16'h0003; // RQ5 RQ7
                        if (cmp_res.diff[7:0] != 8'h00) begin
                           s_d.pc = s_q.pc + 16'h0003 + {{8{s_q.opb[15]}}, s_q.opb[15:8]}; // RQ4 RQ5
                           s_d.taken = 1'b1;
                        end
                        s_d.flg.cy = cmp_res.flg.cy; // RQ6
                     end
                     bace_pkg::BACE_OP_CLRA: begin
                        s_d.acc = 8'h00; // RQ8
                        nz = nz8(8'h00);
                        s_d.flg.n = nz[1];
                        s_d.flg.z = nz[0];
                     end
                     bace_pkg::BACE_OP_CLRB: begin
                        if (s_q.ctrl[`BACE_CTRL_DIRBIT]) begin
                           s_d.bits[s_q.ctrl[`BACE_CTRL_BITSEL +: 3]] = 1'b0; // RQ9
                           // port latch targets take two extra states
                           if (s_q.ctrl[`BACE_CTRL_PORTTGT]) begin
                              s_d.wait_cnt = `BACE_PORT_EXTRA; // RQ10
                              s_d.st = bace_pkg::BACE_ST_WAIT;
                           end
                        end else begin
                           s_d.flg.cy = 1'b0; // RQ9
                        end
                     end
                     bace_pkg::BACE_OP_CMP: begin
                        // difference kept for observation only, opa untouched
                        s_d.res = cmp_res.diff; // RQ11
                        s_d.flg = cmp_res.flg; // RQ15
                     end
                     bace_pkg::BACE_OP_CPLA: begin
                        s_d.acc = ~s_q.acc; // RQ16
                        nz = nz8(~s_q.acc);
                        s_d.flg.n = nz[1];
                        s_d.flg.z = nz[0];
                     end
                     default: s_d.illegal = 1'b1;
                  endcase
               end
            end
         end
         bace_pkg::BACE_ST_WAIT: begin
            s_d.wait_cnt = s_q.wait_cnt - 2'h1;
            if (s_q.wait_cnt == 2'h1) begin
               s_d.st = bace_pkg::BACE_ST_DONE;
            end
         end
         bace_pkg::BACE_ST_DONE: s_d.st = bace_pkg::BACE_ST_IDLE;
         default: s_d.st = bace_pkg::BACE_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign wb_ack_o = s_q.ack;
   assign wb_dat_o = s_q.rdat;
   assign busy_o   = s_q.st != bace_pkg::BACE_ST_IDLE;
   // check helpers: a write strobe, and a legal instruction starting
   assign hit_w    = wb_cyc_i && wb_stb_i && wb_we_i && !s_q.ack;
   assign go_ok    = s_q.st == bace_pkg::BACE_ST_IDLE && s_q.ctrl[`BACE_CTRL_GO] && legal;

   ////////////////////////////////////////////////////////////////////////
   a_anl_clear_cy: assert property (@(posedge clk_i) disable iff (rst_i) // RQ1
      (s_q.st == bace_pkg::BACE_ST_IDLE && s_q.ctrl[0] && legal
       && op == bace_pkg::BACE_OP_ANLC && s_q.ctrl[`BACE_CTRL_DIRBIT])
      |=> (s_q.flg.cy == ($past(s_q.flg.cy) && $past(srcbit))))
      else $error("bit and carry wrong");

   a_anl_only_cy: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
      (s_q.st == bace_pkg::BACE_ST_IDLE && s_q.ctrl[0]
       && op == bace_pkg::BACE_OP_ANLC)
      |=> $stable(s_q.flg[3:0]) && $stable(s_q.bits))
      else $error("bit and touched other state");

   a_compare_branch_ne_op_target: assert property (@(posedge clk_i) disable iff (rst_i) // RQ5
      (s_q.st == bace_pkg::BACE_ST_IDLE && s_q.ctrl[0] && legal
       && op == bace_pkg::BACE_OP_COMPARE_BRANCH_NE_OP && !(hit_w))
      |=> s_q.pc == $past(s_q.pc) + 16'h0003
          + (s_q.taken ? {{8{$past(s_q.opb[15])}}, $past(s_q.opb[15:8])} : 16'h0000))
      else $error("branch target wrong");

   a_compare_branch_ne_op_carry: assert property (@(posedge clk_i) disable iff (rst_i) // RQ6
      (s_q.st == bace_pkg::BACE_ST_IDLE && s_q.ctrl[0] && legal
       && op == bace_pkg::BACE_OP_COMPARE_BRANCH_NE_OP)
      |=> s_q.flg.cy == ($past(s_q.opa[7:0]) < $past(cmp_src[7:0]))
          && s_q.taken == ($past(s_q.opa[7:0]) != $past(cmp_src[7:0])))
      else $error("branch carry or decision wrong");

   a_clra_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RQ8
      (s_q.st == bace_pkg::BACE_ST_IDLE && s_q.ctrl[0] && legal
       && op == bace_pkg::BACE_OP_CLRA && !hit_w)
      |=> s_q.acc == 8'h00 && s_q.flg.z && !s_q.flg.n)
      else $error("clear accumulator wrong");

   a_port_extra: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
      (s_q.st == bace_pkg::BACE_ST_IDLE && s_q.ctrl[0] && legal
       && op == bace_pkg::BACE_OP_CLRB && s_q.ctrl[`BACE_CTRL_DIRBIT]
       && s_q.ctrl[`BACE_CTRL_PORTTGT])
      |=> busy_o [*3] ##1 !busy_o)
      else $error("port clear timing wrong");

   a_cmp_keeps: assert property (@(posedge clk_i) disable iff (rst_i) // RQ11
      (s_q.st == bace_pkg::BACE_ST_IDLE && s_q.ctrl[0] && legal
       && op == bace_pkg::BACE_OP_CMP && !hit_w)
      |=> $stable(s_q.opa) && s_q.res == $past(s_q.opa) - $past(cmp_src))
      else $error("compare result wrong");

   a_cpla_inv: assert property (@(posedge clk_i) disable iff (rst_i) // RQ16
      (s_q.st == bace_pkg::BACE_ST_IDLE && s_q.ctrl[0] && legal
       && op == bace_pkg::BACE_OP_CPLA && !hit_w)
      |=> s_q.acc == ~$past(s_q.acc) && $stable(s_q.flg[4:2]))
      else $error("complement accumulator wrong");

   a_prefix_gate: assert property (@(posedge clk_i) disable iff (rst_i) // RQ17 RQ18
      (s_q.st == bace_pkg::BACE_ST_IDLE && s_q.ctrl[0] && !legal)
      |=> s_q.illegal && $stable(s_q.acc))
      else $error("missing prefix not refused");

   a_clrb_carry: assert property (@(posedge clk_i) disable iff (rst_i) // RQ9
      (go_ok && op == bace_pkg::BACE_OP_CLRB && !s_q.ctrl[`BACE_CTRL_DIRBIT])
      |=> !s_q.flg.cy && $stable(s_q.flg[3:0]) && $stable(s_q.bits))
      else $error("carry clear wrong");

   a_clrb_bit: assert property (@(posedge clk_i) disable iff (rst_i) // RQ9
      (go_ok && op == bace_pkg::BACE_OP_CLRB && s_q.ctrl[`BACE_CTRL_DIRBIT])
      |=> !s_q.bits[$past(s_q.ctrl[`BACE_CTRL_BITSEL +: 3])] && $stable(s_q.flg))
      else $error("bit clear wrong");

   a_cmp_cy8: assert property (@(posedge clk_i) disable iff (rst_i) // RQ12 RQ14
      (go_ok && op == bace_pkg::BACE_OP_CMP && wid == bace_pkg::BACE_W8)
      |=> s_q.flg.cy == ($past(s_q.opa[7:0]) < $past(cmp_src[7:0])))
      else $error("byte compare carry wrong");

   a_cmp_ov32: assert property (@(posedge clk_i) disable iff (rst_i) // RQ13
      (go_ok && op == bace_pkg::BACE_OP_CMP && wid == bace_pkg::BACE_W32)
      |=> s_q.flg.ov == ($past(s_q.opa[31]) != $past(cmp_src[31])
                         && s_q.res[31] != $past(s_q.opa[31])))
      else $error("compare overflow wrong");

   a_cmp_nz32: assert property (@(posedge clk_i) disable iff (rst_i) // RQ20
      (go_ok && op == bace_pkg::BACE_OP_CMP && wid == bace_pkg::BACE_W32)
      |=> s_q.flg.n == s_q.res[31] && s_q.flg.z == (s_q.res == 32'h0000_0000))
      else $error("compare sign or zero wrong");

   a_dword_fill: assert property (@(posedge clk_i) disable iff (rst_i) // RQ19
      (go_ok && op == bace_pkg::BACE_OP_CMP && wid == bace_pkg::BACE_W32
       && s_q.ctrl[`BACE_CTRL_SRCMODE +: 2] == 2'h2)
      |=> s_q.res == $past(s_q.opa)
          - {{16{$past(s_q.ctrl[`BACE_CTRL_ONEFILL])}}, $past(s_q.opb[15:0])})
      else $error("immediate fill wrong");

   a_compare_branch_ne_op_keeps: assert property (@(posedge clk_i) disable iff (rst_i) // RQ4
      (go_ok && op == bace_pkg::BACE_OP_COMPARE_BRANCH_NE_OP && !hit_w)
      |=> $stable(s_q.opa) && $stable(s_q.opb))
      else $error("branch touched its operands");

   a_anl_dir_only: assert property (@(posedge clk_i) disable iff (rst_i) // RQ3
      (go_ok && op == bace_pkg::BACE_OP_ANLC && !s_q.ctrl[`BACE_CTRL_DIRBIT])
      |=> s_q.illegal && $stable(s_q.flg))
      else $error("bit and took a carry source");

   a_cpla_nz: assert property (@(posedge clk_i) disable iff (rst_i) // RQ16 RQ20
      (go_ok && op == bace_pkg::BACE_OP_CPLA && !hit_w)
      |=> s_q.flg.n == s_q.acc[7] && s_q.flg.z == (s_q.acc == 8'h00))
      else $error("complement flags wrong");

   a_busy_once: assert property (@(posedge clk_i) disable iff (rst_i) // RQ10
      (s_q.st == bace_pkg::BACE_ST_IDLE && s_q.ctrl[`BACE_CTRL_GO]
       && !(legal && op == bace_pkg::BACE_OP_CLRB && s_q.ctrl[`BACE_CTRL_DIRBIT]
            && s_q.ctrl[`BACE_CTRL_PORTTGT]))
      |=> busy_o ##1 !busy_o)
      else $error("plain instruction timing wrong");
endmodule

// ==== bace_consts.svh ====
`ifndef BACE_CONSTS_SVH
`define BACE_CONSTS_SVH
// register offsets (byte addresses, one word each)
`define BACE_ADR_CTRL     8'h00
`define BACE_ADR_OPA      8'h04
`define BACE_ADR_OPB      8'h08
`define BACE_ADR_PC       8'h0c
`define BACE_ADR_ACC      8'h10
`define BACE_ADR_FLAGS    8'h14
`define BACE_ADR_STAT     8'h18
`define BACE_ADR_RES      8'h1c
// control register fields
`define BACE_CTRL_GO      0
`define BACE_CTRL_OP_LO   4
`define BACE_CTRL_OP_W    4
`define BACE_CTRL_WID_LO  8
`define BACE_CTRL_NATIVE  10
`define BACE_CTRL_PREFIX  11
`define BACE_CTRL_BITSEL  12
`define BACE_CTRL_PORTTGT 15
`define BACE_CTRL_SRCMODE 16
`define BACE_CTRL_ONEFILL 18
`define BACE_CTRL_INVSRC  19
`define BACE_CTRL_LEGACY  20
`define BACE_CTRL_DIRBIT  21
// flag layout
`define BACE_FLG_CY       4
`define BACE_FLG_AC       3
`define BACE_FLG_OV       2
`define BACE_FLG_N        1
`define BACE_FLG_Z        0
// execution timing
`define BACE_PORT_EXTRA   2'h2
`define BACE_ACK_PERIOD   1
`endif

// ==== bace_pkg.sv ====
package bace_pkg;
   typedef enum logic [3:0] {
      BACE_OP_NOP   = 4'h0,
      BACE_OP_ANLC  = 4'h1,
      BACE_OP_COMPARE_BRANCH_NE_OP  = 4'h2,
      BACE_OP_CLRA  = 4'h3,
      BACE_OP_CLRB  = 4'h4,
      BACE_OP_CMP   = 4'h5,
      BACE_OP_CPLA  = 4'h6
   } bace_op_t;
   typedef enum logic [1:0] {
      BACE_W8  = 2'h0,
      BACE_W16 = 2'h1,
      BACE_W32 = 2'h2
   } bace_wid_t;
   typedef enum logic [1:0] {
      BACE_ST_IDLE = 2'b00,
      BACE_ST_WAIT = 2'b01,
      BACE_ST_DONE = 2'b10
   } bace_state_t;
   typedef struct packed {
      logic cy;
      logic ac;
      logic ov;
      logic n;
      logic z;
   } bace_flags_t;
   typedef struct packed {
      logic [31:0] diff;
      bace_flags_t flg;
   } bace_cmp_t;
   typedef struct packed {
      logic [7:0]  adr;
      logic        we;
      logic [31:0] dat;
      logic [3:0]  sel;
   } bace_wb_req_t;
endpackage

// ==== bace_compare.sv ====
`timescale 1ns/1ps
`include "bace_consts.svh"
// width-selectable subtractor, difference and flags
module bace_compare (
   input  wire logic              [31:0] dst_i,
   input  wire logic              [31:0] src_i,
   input  wire bace_pkg::bace_wid_t      wid_i,
   output bace_pkg::bace_cmp_t           res_o
);
   logic [32:0] d;
   logic [4:0]  lo;
   logic        sd;
   logic        ss;
   logic        sr;
   always_comb begin
      d  = {1'b0, dst_i} - {1'b0, src_i};
      lo = {1'b0, dst_i[3:0]} - {1'b0, src_i[3:0]};
      res_o.diff = d[31:0];
      res_o.flg.ac = lo[4];
      case (wid_i)
         bace_pkg::BACE_W8: begin
            // carry and overflow from the top byte of the width in use
            res_o.flg.cy = dst_i[7:0] < src_i[7:0]; // RQ12 RQ14
            sd = dst_i[7];
            ss = src_i[7];
            sr = d[7];
            res_o.flg.z = d[7:0] == 8'h00;
         end
         bace_pkg::BACE_W16: begin
            res_o.flg.cy = dst_i[15:0] < src_i[15:0]; // RQ14
            sd = dst_i[15];
            ss = src_i[15];
            sr = d[15];
            res_o.flg.z = d[15:0] == 16'h0000;
         end
         default: begin
            res_o.flg.cy = d[32]; // RQ14
            sd = dst_i[31];
            ss = src_i[31];
            sr = d[31];
            res_o.flg.z = d[31:0] == 32'h0000_0000;
         end
      endcase
      res_o.flg.ov = (sd != ss) && (sr != sd); // RQ13
      res_o.flg.n  = sr; // RQ20
   end
endmodule

// ==== bit_and_compare_clear_exec_tb.sv ====
`timescale 1ns/1ps
`include "bace_consts.svh"
module bit_and_compare_clear_exec_tb;
   logic        clk_i    = 1'b0;
   logic        rst_i    = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i  = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        busy_o;
   int          mismatches = 0;
   int          cmp_count  = 0;
   int          cycles     = 0;
   int          busy_cnt   = 0;
   logic [31:0] rd;
   logic [36:0] e;
   logic [31:0] d;
   logic [31:0] s;
   logic [7:0]  rel;
   // control word pieces
   localparam logic [31:0] c_leg = 32'h1 << `BACE_CTRL_LEGACY;
   localparam logic [31:0] c_nat = 32'h1 << `BACE_CTRL_NATIVE;
   localparam logic [31:0] c_pfx = 32'h1 << `BACE_CTRL_PREFIX;
   localparam logic [31:0] c_dir = 32'h1 << `BACE_CTRL_DIRBIT;
   localparam logic [31:0] c_prt = 32'h1 << `BACE_CTRL_PORTTGT;
   localparam logic [31:0] c_one = 32'h1 << `BACE_CTRL_ONEFILL;
   localparam logic [31:0] c_imm = 32'h2 << `BACE_CTRL_SRCMODE;
   logic [31:0] cd [5] = '{32'hc9, 32'h10, 32'h80, 32'h1234_0000, 32'h8000_0000};
   logic [31:0] cs [5] = '{32'h54, 32'h10, 32'h01, 32'h1234_0001, 32'h0000_0001};
   int          cw [5] = '{0, 0, 0, 1, 2};

   always #2.5 clk_i = ~clk_i;

   bace_exec bace_exec_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o));

   ////////////////////////////////////////////////////////////////////////////////
   // busy is counted beside the bus so a one-cycle pulse near the ack is not missed
   always @(negedge clk_i) begin
      if (busy_o === 1'b1) busy_cnt++;
   end

   // a hang costs a mismatch and ends the run
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // classic single cycle; ack and data taken on the rising edge, release right after it
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hf;
      wb_dat_i <= dat;
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      @(posedge clk_i);
      chk({31'h0, wb_ack_o}, 32'h0);
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      wb(1'b1, adr, dat);
   endtask

   task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
      wb(1'b0, adr, 32'h0);
      chk(rd, exp);
   endtask

   // nb < 0 skips the busy length check
   task automatic exec(input bace_pkg::bace_op_t op, input logic [31:0] x, input int nb);
      busy_cnt = 0;
      wr(`BACE_ADR_CTRL, x | (32'(op) << `BACE_CTRL_OP_LO) | 32'h1);
      repeat (6) @(negedge clk_i);
      if (nb >= 0) chk(32'(busy_cnt), 32'(nb));
   endtask

   // own subtractor: {difference, cy, ac, ov, n, z}
   function automatic logic [36:0] cmp_ref(input logic [31:0] a, input logic [31:0] b,
                                           input int w);
      logic [32:0] m;
      logic [32:0] df;
      logic [31:0] r;
      int          t;
      t  = 8 << w;
      m  = (33'h1 << t) - 33'h1;
      df = {1'b0, a & m[31:0]} - {1'b0, b & m[31:0]};
      r  = df[31:0] & m[31:0];
      return {a - b, df[32], a[3:0] < b[3:0], (a[t-1] != b[t-1]) && (r[t-1] != a[t-1]),
              r[t-1], r == 32'h0};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk(`BACE_ADR_FLAGS, 32'h0);
      rdchk(`BACE_ADR_ACC, 32'h0);
      wr(8'h20, 32'hdead_beef);
      rdchk(8'h20, 32'h0);
      // bit and into carry, plain and inverted, bits 0 (set) and 7 (clear)
      wr(`BACE_ADR_ACC, 32'h0f5c);
      for (int i = 0; i < 4; i++) begin
         wr(`BACE_ADR_FLAGS, 32'h1f);
         exec(bace_pkg::BACE_OP_ANLC, c_leg | c_dir | (32'(i[0]) << `BACE_CTRL_INVSRC)
              | (32'(i[1] ? 7 : 0) << `BACE_CTRL_BITSEL), 1);
         rdchk(`BACE_ADR_FLAGS, {27'h0, i[0] ^ !i[1], 4'hf});
         rdchk(`BACE_ADR_ACC, 32'h0f5c);
      end
      exec(bace_pkg::BACE_OP_ANLC, c_leg, 1);
      wb(1'b0, `BACE_ADR_STAT, 32'h0);
      chk(rd & 32'h8, 32'h8);
      rdchk(`BACE_ADR_FLAGS, 32'h1f);
      // compare and branch, four pairings, equal, below, above, wrap backwards
      for (int i = 0; i < 4; i++) begin
         d   = (i == 3) ? 32'h00 : (i == 2) ? 32'h60 : 32'h34;
         s   = (i == 0) ? 32'h34 : (i == 3) ? 32'hff : 32'h56;
         rel = (i == 0) ? 8'h10 : (i == 1) ? 8'hf0 : (i == 2) ? 8'h7f : 8'h80;
         wr(`BACE_ADR_PC, 32'h1000);
         wr(`BACE_ADR_ACC, {24'h0, d[7:0]});
         wr(`BACE_ADR_OPA, d);
         wr(`BACE_ADR_OPB, {16'h0, rel, s[7:0]});
         wr(`BACE_ADR_FLAGS, (d < s) ? 32'h0 : 32'h10);
         exec(bace_pkg::BACE_OP_COMPARE_BRANCH_NE_OP, c_leg | (32'(i) << `BACE_CTRL_SRCMODE), 1);
         rdchk(`BACE_ADR_PC, 32'h1003 + ((d != s) ? {{24{rel[7]}}, rel} : 32'h0));
         wb(1'b0, `BACE_ADR_FLAGS, 32'h0);
         chk({31'h0, rd[`BACE_FLG_CY]}, {31'h0, d < s});
         wb(1'b0, `BACE_ADR_STAT, 32'h0);
         chk(rd & 32'h4, (d != s) ? 32'h4 : 32'h0);
         rdchk(`BACE_ADR_OPA, d);
         rdchk(`BACE_ADR_OPB, {16'h0, rel, s[7:0]});
      end
      // compare at three widths, alternately native map and prefixed compatibility map
      for (int i = 0; i < 5; i++) begin
         e = cmp_ref(cd[i], cs[i], cw[i]);
         wr(`BACE_ADR_OPA, cd[i]);
         wr(`BACE_ADR_OPB, cs[i]);
         exec(bace_pkg::BACE_OP_CMP, (i[0] ? c_nat : c_pfx)
              | (32'(cw[i]) << `BACE_CTRL_WID_LO), 1);
         rdchk(`BACE_ADR_FLAGS, {27'h0, e[4:0]});
         rdchk(`BACE_ADR_RES, e[36:5]);
         rdchk(`BACE_ADR_OPA, cd[i]);
      end
      // double word against a sixteen-bit immediate, zero fill then one fill
      wr(`BACE_ADR_OPA, 32'hffff_8001);
      wr(`BACE_ADR_OPB, 32'habcd_8001);
      for (int i = 0; i < 2; i++) begin
         e = cmp_ref(32'hffff_8001, {i[0] ? 16'hffff : 16'h0, 16'h8001}, 2);
         exec(bace_pkg::BACE_OP_CMP, c_nat | c_imm | (i[0] ? c_one : 32'h0)
              | (32'(2) << `BACE_CTRL_WID_LO), 1);
         rdchk(`BACE_ADR_FLAGS, {27'h0, e[4:0]});
      end
      // clear and complement of the accumulator keep carry, aux and overflow
      wr(`BACE_ADR_ACC, 32'h0f5c);
      wr(`BACE_ADR_FLAGS, 32'h1c);
      exec(bace_pkg::BACE_OP_CLRA, c_leg, 1);
      rdchk(`BACE_ADR_ACC, 32'h0f00);
      rdchk(`BACE_ADR_FLAGS, 32'h1d);
      wr(`BACE_ADR_ACC, 32'h0f5c);
      wr(`BACE_ADR_FLAGS, 32'h1c);
      exec(bace_pkg::BACE_OP_CPLA, c_leg, 1);
      rdchk(`BACE_ADR_ACC, 32'h0fa3);
      rdchk(`BACE_ADR_FLAGS, 32'h1e);
      exec(bace_pkg::BACE_OP_CPLA, c_leg, 1);
      exec(bace_pkg::BACE_OP_CPLA, c_leg, 1);
      wr(`BACE_ADR_ACC, 32'h0fff);
      exec(bace_pkg::BACE_OP_CPLA, c_leg, 1);
      rdchk(`BACE_ADR_FLAGS, 32'h1d);
      // bit clear: direct bit, port latch bit (two extra states), then carry
      wr(`BACE_ADR_ACC, 32'h0f5c);
      wr(`BACE_ADR_FLAGS, 32'h1f);
      exec(bace_pkg::BACE_OP_CLRB, c_leg | c_dir | (32'(3) << `BACE_CTRL_BITSEL), 1);
      rdchk(`BACE_ADR_ACC, 32'h075c);
      exec(bace_pkg::BACE_OP_CLRB, c_leg | c_dir | c_prt, 3);
      rdchk(`BACE_ADR_ACC, 32'h065c);
      rdchk(`BACE_ADR_FLAGS, 32'h1f);
      exec(bace_pkg::BACE_OP_CLRB, c_leg, 1);
      rdchk(`BACE_ADR_FLAGS, 32'h0f);
      rdchk(`BACE_ADR_ACC, 32'h065c);
      // escape prefix: missing in either map is refused and leaves state alone
      exec(bace_pkg::BACE_OP_CMP, 32'h0, -1);
      wb(1'b0, `BACE_ADR_STAT, 32'h0);
      chk(rd & 32'h8, 32'h8);
      exec(bace_pkg::BACE_OP_CLRA, c_nat | c_leg, -1);
      wb(1'b0, `BACE_ADR_STAT, 32'h0);
      chk(rd & 32'h8, 32'h8);
      rdchk(`BACE_ADR_ACC, 32'h065c);
      exec(bace_pkg::BACE_OP_CLRA, c_nat | c_leg | c_pfx, 1);
      rdchk(`BACE_ADR_ACC, 32'h0600);
      end_of_test();
   end
endmodule
